// >>> bench/cphc_mem_model.sv
`timescale 1ns/1ps
// Data RAM port; instruction fetch has its own path with no shared bus
module cphc_mem_model (
    input wire logic clock,
    input wire logic memAccessEnable,
    input wire logic [31:0] loadWord,
    output logic [31:0] memData
);
    logic [31:0] lastData_reg = 32'h00000000;
    // Answers within the MEM cycle; released bus shows the inverse pattern
    assign memData = memAccessEnable ? loadWord : ~lastData_reg;
    // Tracks the last bus value so an idle bus never repeats it
    always_ff @(posedge clock) begin
        lastData_reg <= memData;
    end
endmodule : cphc_mem_model

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import cphc_pkg::*;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic idValid = 1'b0;
    cphc_kind_t idKind = KIND_NONE;
    cphc_reg_t idDest = 5'h00;
    cphc_reg_t idDest2 = 5'h00;
    logic idWrites = 1'b0;
    cphc_reg_t idSrcA = 5'h00;
    cphc_reg_t idSrcB = 5'h00;
    logic idUsesA = 1'b0;
    logic idUsesB = 1'b0;
    cphc_sys_t idSysSel = 2'h0;
    logic irqRequest = 1'b0;
    logic branchTarget = 1'b0;
    logic targetLen4 = 1'b0;
    logic targetAddrBit1 = 1'b0;
    logic memMisaligned = 1'b0;
    logic [31:0] seed = 32'h0000782F;
    logic [31:0] rfDataA = 32'h00000000;
    logic [31:0] rfDataB = 32'h00000000;
    logic [31:0] exResult = 32'h00000000;
    logic [31:0] loadWord = 32'h00000000;
    logic [31:0] memData;
    logic stallId, holdAll, fetchEnable, fetchSplit, fetchSecondHalf;
    logic memAccessEnable, exValid, irqTaken, wbWeA, wbWeB;
    cphc_fwd_t fwdSelA, fwdSelB;
    logic [31:0] exOperandA, exOperandB;
    cphc_reg_t wbDestA, wbDestB;
    logic [64:0] opQ[$];
    logic [64:0] opNote;
    logic heldLast = 1'b0;
    cphc_reg_t wbQ[$];
    int errors = 0;
    int nTests = 0;
    cphc_kind_t prod[3] = '{KIND_LOAD, KIND_MULH, KIND_MULW};

    cphc_hazard_control DUT (.clock, .sys_rst(sysRst), .idValid, .idKind,
        .idDest, .idDest2, .idWrites, .idSrcA, .idSrcB, .idUsesA, .idUsesB,
        .idSysSel, .irqRequest, .branchTarget, .targetLen4, .targetAddrBit1,
        .memMisaligned, .rfDataA, .rfDataB, .exResult, .memData, .stallId,
        .holdAll, .fetchEnable, .fetchSplit, .fetchSecondHalf,
        .memAccessEnable, .fwdSelA, .fwdSelB, .exOperandA, .exOperandB,
        .exValid, .irqTaken, .wbWeA, .wbWeB, .wbDestA, .wbDestB);
    cphc_mem_model memSide (.clock, .memAccessEnable, .loadWord, .memData);

    // Core clock, 4 ns period
    initial forever #2 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic give_verdict();
        if (errors == 0 && nTests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        nTests++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask : check

    task automatic pop_check(input cphc_reg_t d);
        if (wbQ.size() == 0) check(1'b1, 1'b0);
        else check(d, wbQ.pop_front());
    endtask : pop_check

    // Presents one instruction and waits, bounded, until decode lets it go
    task automatic issue(input cphc_kind_t k, input cphc_reg_t d,
            input cphc_reg_t d2, input cphc_reg_t s, input cphc_sys_t sel,
            input int stalls, input cphc_fwd_t src);
        int n;
        logic ok;
        logic [31:0] want;
        logic [31:0] wantB;
        cphc_fwd_t seen;
        cphc_fwd_t seenB;
        n = 0;
        ok = 1'b0;
        idValid <= 1'b1;
        idKind <= k;
        idDest <= d;
        idDest2 <= d2;
        idWrites <= (d != 5'h00) || (d2 != 5'h00);
        idSrcA <= s;
        idSrcB <= s;
        idUsesA <= (s != 5'h00);
        idUsesB <= (s != 5'h00);
        idSysSel <= sel;
        repeat (8) begin
            @(negedge clock);
            want = (src == FWD_EX) ? exResult :
                (src == FWD_MEM) ? memData : rfDataA;
            wantB = (src == FWD_EX) ? exResult :
                (src == FWD_MEM) ? memData : rfDataB;
            seen = fwdSelA;
            seenB = fwdSelB;
            if (!stallId && !holdAll && !irqRequest) begin
                ok = 1'b1;
                break;
            end
            n += int'(stallId);
            @(posedge clock);
        end
        if (!ok) begin
            errors++;
            give_verdict();
        end
        check(n, stalls);
        check(fetchEnable, 1'b1);
        if (s != 5'h00) check(seen, src);
        if (s != 5'h00) check(seenB, src);
        @(posedge clock);
        // One note per issued slot; top bit marks a source worth checking
        opQ.push_back({s != 5'h00, want, wantB});
        if (d != 5'h00 && d != d2) wbQ.push_back(d);
        if (d2 != 5'h00) wbQ.push_back(d2);
    endtask : issue

    // Fresh random operands and load data every cycle
    always @(posedge clock) begin
        seed <= xs(seed);
        rfDataA <= seed;
        rfDataB <= ~seed;
        exResult <= {seed[15:0], seed[31:16]};
        loadWord <= seed ^ 32'h5A5A5A5A;
    end

    // Watches issued operands and write-backs against the noted queue
    // A frozen pipe shows the same EX slot twice, so skip the repeat
    always @(negedge clock) begin
        if (exValid === 1'b1 && !heldLast) begin
            if (opQ.size() == 0) check(1'b1, 1'b0);
            else begin
                opNote = opQ.pop_front();
                if (opNote[64]) begin
                    check(exOperandA, opNote[63:32]);
                    check(exOperandB, opNote[31:0]);
                end
            end
        end
        heldLast = (holdAll === 1'b1);
        if (wbWeA === 1'b1) pop_check(wbDestA);
        if (wbWeB === 1'b1) pop_check(wbDestB);
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        sysRst <= 1'b0;
        issue(KIND_LOAD, 5'h06, 5'h00, 5'h04, 2'h0, 0, FWD_RF);
        issue(KIND_ALU, 5'h06, 5'h00, 5'h06, 2'h0, 1, FWD_MEM);
        issue(KIND_ALU, 5'h07, 5'h00, 5'h06, 2'h0, 0, FWD_EX);
        // Producers at distance two, then back to back
        foreach (prod[i]) begin
            issue(prod[i], 5'h08, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            issue(KIND_NONE, 5'h00, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            issue(KIND_ALU, 5'h09, 5'h00, 5'h08, 2'h0, 0, FWD_MEM);
            issue(prod[i], 5'h08, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            issue(KIND_ALU, 5'h09, 5'h00, 5'h08, 2'h0, 1, FWD_MEM);
        end
        // Return-PC write then read at gaps of zero to two
        for (int sel = 1; sel <= 2; sel++) begin
            for (int gap = 0; gap < 3; gap++) begin
                issue(KIND_SYSW, 5'h00, 5'h00, 5'h03, 2'(sel), 0, FWD_RF);
                repeat (gap)
                    issue(KIND_NONE, 5'h00, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
                issue(KIND_SYSR, 5'h00, 5'h00, 5'h00, 2'(sel), 2 - gap,
                    FWD_RF);
            end
        end
        issue(KIND_SYSW, 5'h00, 5'h00, 5'h03, 2'h1, 0, FWD_RF);
        issue(KIND_SYSR, 5'h00, 5'h00, 5'h00, 2'h2, 0, FWD_RF);
        // Interrupt squashes the slot behind a load; load still retires
        issue(KIND_LOAD, 5'h0A, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
        idKind <= KIND_ALU;
        idDest <= 5'h0B;
        irqRequest <= 1'b1;
        @(posedge clock);
        // Squashed slot is re-presented later, not retaken here
        idValid <= 1'b0;
        irqRequest <= 1'b0;
        @(negedge clock);
        check(irqTaken, 1'b1);
        @(posedge clock);
        issue(KIND_ALU, 5'h0B, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
        // Word multiply with zero or same upper dest, then misaligned load
        for (int j = 0; j < 2; j++) begin
            issue(KIND_MULW, 5'h0E, j ? 5'h0E : 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            issue(KIND_LOAD, 5'h0D, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            issue(KIND_NONE, 5'h00, 5'h00, 5'h00, 2'h0, 0, FWD_RF);
            memMisaligned <= 1'b1;
            @(negedge clock);
            check(holdAll, 1'b1);
            check(memAccessEnable, 1'b1);
            @(posedge clock);
            memMisaligned <= 1'b0;
        end
        // Branch targets of every length and alignment
        for (int c = 0; c < 4; c++) begin
            idValid <= 1'b0;
            branchTarget <= 1'b1;
            targetLen4 <= c[1];
            targetAddrBit1 <= c[0];
            @(negedge clock);
            check(fetchSplit, c[1] & c[0]);
            @(posedge clock);
            branchTarget <= 1'b0;
            @(negedge clock);
            check(fetchSecondHalf, c[1] & c[0]);
            @(posedge clock);
        end
        repeat (8) @(posedge clock);
        check(wbQ.size(), 0);
        check(opQ.size(), 0);
        give_verdict();
    end
endmodule : tb

// >>> rtl/cphc_consts.svh
`ifndef CPHC_CONSTS_SVH
`define CPHC_CONSTS_SVH
// Register zero never holds a result
`define CPHC_REG_ZERO 5'h00
// System register selectors
`define CPHC_SYS_NONE 2'h0
`define CPHC_SYS_IRET 2'h1
`define CPHC_SYS_FRET 2'h2
// Clocks of a return-PC write with a back-to-back read
`define CPHC_SYSW_CLOCKS 3
// Safe distances that avoid any interlock
`define CPHC_SYSR_DIST 3
`define CPHC_LOAD_DIST 2
`endif

// >>> rtl/cphc_hazard_control.sv
`timescale 1ns/1ps
`include "cphc_consts.svh"
// Summary of operation
// RULE1 - Hold return-PC read behind same-register write
// RULE2 - Back-to-back return-PC write takes three clocks
// RULE3 - No stall when read is three away
// RULE4 - Stall load consumer once; distance two free
// RULE5 - Stall halfword multiply consumer once only
// RULE6 - Split fetch only for unaligned 4-byte target
// RULE7 - Separate fetch and data access paths
// RULE8 - Fetch never waits on data access; fetch stops for the misaligned hold
// RULE9 - MEM of one overlaps IF of fourth
// RULE10 - Forward execute result into next decode
// RULE11 - Forward load data from memory stage
// RULE12 - Interrupt never drops load or multiply writeback
// RULE13 - Word multiply writes correct despite misaligned load
module cphc_hazard_control (
    input logic clock,
    input logic sys_rst,
    input logic idValid,
    input cphc_pkg::cphc_kind_t idKind,
    input cphc_pkg::cphc_reg_t idDest,
    input cphc_pkg::cphc_reg_t idDest2,
    input logic idWrites,
    input cphc_pkg::cphc_reg_t idSrcA,
    input cphc_pkg::cphc_reg_t idSrcB,
    input logic idUsesA,
    input logic idUsesB,
    input cphc_pkg::cphc_sys_t idSysSel,
    input logic irqRequest,
    input logic branchTarget,
    input logic targetLen4,
    input logic targetAddrBit1,
    input logic memMisaligned,
    input logic [31:0] rfDataA,
    input logic [31:0] rfDataB,
    input logic [31:0] exResult,
    input logic [31:0] memData,
    output logic stallId,
    output logic holdAll,
    output logic fetchEnable,
    output logic fetchSplit,
    output logic fetchSecondHalf,
    output logic memAccessEnable,
    output cphc_pkg::cphc_fwd_t fwdSelA,
    output cphc_pkg::cphc_fwd_t fwdSelB,
    output logic [31:0] exOperandA,
    output logic [31:0] exOperandB,
    output logic exValid,
    output logic irqTaken,
    output logic wbWeA,
    output logic wbWeB,
    output cphc_pkg::cphc_reg_t wbDestA,
    output cphc_pkg::cphc_reg_t wbDestB
);
    import cphc_pkg::*;

    // True when an older writer produces what decode reads
    function automatic logic hits(input logic v, input cphc_reg_t d,
                                  input cphc_reg_t s, input logic u);
        return v && u && (d == s) && (d != `CPHC_REG_ZERO);
    endfunction : hits

    // Late result: not ready before the memory stage
    function automatic logic isLate(input cphc_kind_t k);
        return (k == KIND_LOAD) || (k == KIND_MULH) || (k == KIND_MULW);
    endfunction : isLate

    // Operand mux shared by both read ports
    function automatic logic [31:0] pick(input cphc_fwd_t f,
                                         input logic [31:0] rf,
                                         input logic [31:0] ex,
                                         input logic [31:0] mem);
        logic [31:0] v;
        v = rf;
        unique case (f)
            FWD_RF: v = rf;
            FWD_EX: v = ex;
            FWD_MEM: v = mem;
        endcase
        return v;
    endfunction : pick

    logic exValid_reg;
    cphc_kind_t exKind_reg;
    cphc_reg_t exDest_reg;
    cphc_reg_t exDest2_reg;
    logic exWrites_reg;
    cphc_sys_t exSysSel_reg;
    logic memValid_reg;
    cphc_kind_t memKind_reg;
    cphc_reg_t memDest_reg;
    cphc_reg_t memDest2_reg;
    logic memWrites_reg;
    cphc_sys_t memSysSel_reg;
    logic misSecond_reg;
    logic alignSecond_reg;
    logic irqTaken_reg;
    logic wbWeA_reg;
    logic wbWeB_reg;
    cphc_reg_t wbDestA_reg;
    cphc_reg_t wbDestB_reg;
    logic [31:0] exOperandA_reg;
    logic [31:0] exOperandB_reg;
    logic exLate;
    logic loadUseStall;
    logic sysRead;
    logic sysStall;
    logic issue;
    logic memWriterOk;
    logic mulSame;

    // Load-use and multiply-use interlock, one idle cycle
    assign exLate = exValid_reg && exWrites_reg && isLate(exKind_reg);
    assign loadUseStall = idValid && exLate
        && (hits(1'b1, exDest_reg, idSrcA, idUsesA)
            || hits(1'b1, exDest_reg, idSrcB, idUsesB)); // RULE4 RULE5

    // Return-PC read waits while the write is in EX or MEM
    assign sysRead = idValid && (idKind == KIND_SYSR)
        && (idSysSel != `CPHC_SYS_NONE);
    assign sysStall = sysRead
        && ((exValid_reg && (exKind_reg == KIND_SYSW)
             && (exSysSel_reg == idSysSel))
            || (memValid_reg && (memKind_reg == KIND_SYSW)
                && (memSysSel_reg == idSysSel))); // RULE1 RULE2 RULE3

    assign stallId = loadUseStall || sysStall;

    // First beat of a misaligned access freezes every stage
    assign holdAll = memValid_reg && memMisaligned && !misSecond_reg;

    // Fetch gated by decode stalls and the misaligned hold, never by aligned data access
    assign fetchEnable = !holdAll && !stallId; // RULE7 RULE8 RULE9
    assign memAccessEnable = memValid_reg
        && ((memKind_reg == KIND_LOAD) || (memKind_reg == KIND_STORE));

    // Only a 4-byte target at a halfword offset needs two fetches
    assign fetchSplit = branchTarget && targetLen4 && targetAddrBit1; // RULE6
    assign fetchSecondHalf = alignSecond_reg;

    // Youngest producer wins; late EX results were interlocked away
    always_comb begin
        fwdSelA = FWD_RF;
        fwdSelB = FWD_RF;
        if (hits(memValid_reg && memWrites_reg, memDest_reg, idSrcA,
                 idUsesA)) begin
            fwdSelA = FWD_MEM; // RULE11
        end
        if (hits(memValid_reg && memWrites_reg, memDest_reg, idSrcB,
                 idUsesB)) begin
            fwdSelB = FWD_MEM; // RULE11
        end
        if (hits(exValid_reg && exWrites_reg && !exLate, exDest_reg,
                 idSrcA, idUsesA)) begin
            fwdSelA = FWD_EX; // RULE10
        end
        if (hits(exValid_reg && exWrites_reg && !exLate, exDest_reg,
                 idSrcB, idUsesB)) begin
            fwdSelB = FWD_EX; // RULE10
        end
    end

    // Interrupt squashes only the decode slot
    assign issue = idValid && !stallId && !irqRequest;

    // Execute stage latch
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            exValid_reg <= 1'b0;
            exKind_reg <= KIND_NONE;
            exDest_reg <= `CPHC_REG_ZERO;
            exDest2_reg <= `CPHC_REG_ZERO;
            exWrites_reg <= 1'b0;
            exSysSel_reg <= `CPHC_SYS_NONE;
        end else if (!holdAll) begin
            exValid_reg <= issue;
            exKind_reg <= issue ? idKind : KIND_NONE;
            exDest_reg <= idDest;
            exDest2_reg <= idDest2;
            exWrites_reg <= issue && idWrites;
            exSysSel_reg <= idSysSel;
        end
    end

    // Operands captured with forwarding applied
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            exOperandA_reg <= 32'h00000000;
            exOperandB_reg <= 32'h00000000;
        end else if (!holdAll && issue) begin
            exOperandA_reg <= pick(fwdSelA, rfDataA, exResult, memData);
            exOperandB_reg <= pick(fwdSelB, rfDataB, exResult, memData);
        end
    end

    // Memory stage latch; older stages ignore interrupts
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            memValid_reg <= 1'b0;
            memKind_reg <= KIND_NONE;
            memDest_reg <= `CPHC_REG_ZERO;
            memDest2_reg <= `CPHC_REG_ZERO;
            memWrites_reg <= 1'b0;
            memSysSel_reg <= `CPHC_SYS_NONE;
        end else if (!holdAll) begin
            memValid_reg <= exValid_reg;
            memKind_reg <= exKind_reg;
            memDest_reg <= exDest_reg;
            memDest2_reg <= exDest2_reg;
            memWrites_reg <= exWrites_reg;
            memSysSel_reg <= exSysSel_reg;
        end
    end

    // Misaligned beat tracking keeps the hold to one cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            misSecond_reg <= 1'b0;
        end else begin
            misSecond_reg <= holdAll;
        end
    end

    // Second fetch of an unaligned target
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alignSecond_reg <= 1'b0;
        end else begin
            alignSecond_reg <= fetchSplit;
        end
    end

    // Interrupt acceptance pulse
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irqTaken_reg <= 1'b0;
        end else begin
            irqTaken_reg <= irqRequest && !holdAll;
        end
    end

    // Same-register word multiply keeps only the upper word
    assign memWriterOk = memValid_reg && memWrites_reg;
    assign mulSame = (memKind_reg == KIND_MULW)
        && (memDest_reg == memDest2_reg);

    // Writeback enables; a held cycle writes nothing twice
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wbWeA_reg <= 1'b0;
            wbWeB_reg <= 1'b0;
            wbDestA_reg <= `CPHC_REG_ZERO;
            wbDestB_reg <= `CPHC_REG_ZERO;
        end else if (holdAll) begin
            wbWeA_reg <= 1'b0;
            wbWeB_reg <= 1'b0;
        end else begin
            wbWeA_reg <= memWriterOk && !mulSame
                && (memDest_reg != `CPHC_REG_ZERO); // RULE12 RULE13
            wbWeB_reg <= memWriterOk && (memKind_reg == KIND_MULW)
                && (memDest2_reg != `CPHC_REG_ZERO); // RULE13
            wbDestA_reg <= memDest_reg;
            wbDestB_reg <= memDest2_reg;
        end
    end

    assign exOperandA = exOperandA_reg;
    assign exOperandB = exOperandB_reg;
    assign exValid = exValid_reg;
    assign irqTaken = irqTaken_reg;
    assign wbWeA = wbWeA_reg;
    assign wbWeB = wbWeB_reg;
    assign wbDestA = wbDestA_reg;
    assign wbDestB = wbDestB_reg;

    // Checks on the interlock, forwarding, fetch and writeback behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    load_stall_a: assert property ( // RULE4
        (idValid && exValid_reg && exWrites_reg
         && (exKind_reg == KIND_LOAD)
         && hits(1'b1, exDest_reg, idSrcA, idUsesA)) |-> stallId
    ) else $error("load consumer not stalled");

    one_idle_a: assert property ( // RULE4
        (loadUseStall && !holdAll) |=> !loadUseStall
    ) else $error("load interlock longer than one cycle");

    mul_stall_a: assert property ( // RULE5
        (idValid && exValid_reg && exWrites_reg
         && (exKind_reg == KIND_MULH)
         && hits(1'b1, exDest_reg, idSrcB, idUsesB)) |-> stallId
    ) else $error("multiply consumer not stalled");

    sys_hold_a: assert property ( // RULE2
        (sysStall && exValid_reg && (exKind_reg == KIND_SYSW)
         && !holdAll) |=> sysStall
    ) else $error("return pc read released too early");

    ex_fwd_a: assert property ( // RULE10
        (exValid_reg && exWrites_reg && (exKind_reg == KIND_ALU)
         && hits(1'b1, exDest_reg, idSrcA, idUsesA))
        |-> (fwdSelA == FWD_EX) && !loadUseStall
    ) else $error("execute result not forwarded");

    align_ok_a: assert property ( // RULE6
        (branchTarget && !(targetLen4 && targetAddrBit1))
        |=> !fetchSecondHalf
    ) else $error("needless align stall");

    fetch_free_a: assert property ( // RULE8
        (memAccessEnable && !stallId && !holdAll) |-> fetchEnable
    ) else $error("fetch waited on data access");

    wb_load_a: assert property ( // RULE12
        (memValid_reg && memWrites_reg && (memKind_reg == KIND_LOAD)
         && (memDest_reg != `CPHC_REG_ZERO) && !holdAll)
        |=> wbWeA && (wbDestA == $past(memDest_reg))
    ) else $error("load result not written back");

    mul_same_a: assert property ( // RULE13
        (memWriterOk && mulSame && !holdAll
         && (memDest_reg != `CPHC_REG_ZERO)) |=> !wbWeA && wbWeB
    ) else $error("word multiply same-register write wrong");

    hold_once_a: assert property ( // RULE9
        holdAll |=> !holdAll && !wbWeA && !wbWeB
    ) else $error("misaligned hold longer than one cycle");

endmodule : cphc_hazard_control

// >>> rtl/cphc_pkg.sv
package cphc_pkg;
    // Class of instruction as seen by the hazard logic
    typedef enum logic [7:0] {
        KIND_NONE = 8'h01,
        KIND_ALU = 8'h02,
        KIND_LOAD = 8'h04,
        KIND_MULH = 8'h08,
        KIND_MULW = 8'h10,
        KIND_SYSW = 8'h20,
        KIND_SYSR = 8'h40,
        KIND_STORE = 8'h80
    } cphc_kind_t;
    // Operand source chosen in decode
    typedef enum logic [2:0] {
        FWD_RF = 3'h1,
        FWD_EX = 3'h2,
        FWD_MEM = 3'h4
    } cphc_fwd_t;
    typedef logic [4:0] cphc_reg_t;
    typedef logic [1:0] cphc_sys_t;
endpackage : cphc_pkg
